// File: rtl/wscs_pkg.sv
// Summary of operation
// RL1 - Opcode 93h: LBA bytes 2-9, length 10-13.
// RL2 - One block received, written to consecutive blocks.
// RL3 - Opcode 7Fh, length 18h, service 000Dh.
// RL4 - 32-byte form: LBA 12-19, count 28-31.
// RL5 - 32-byte form needs protection type 001b.
// RL6 - Bytes 20-23 give first block reference tag.
// RL7 - Owner bit set: masked application tag compare.
// RL8 - Owner bit clear: ignore tag and mask.
// RL9 - Write user data, plus protection when enabled.
// RL10 - One status byte ends every command.
// RL11 - Code in bits 5:1, others zero.
// RL12 - Good completion returns 00h.
// RL13 - Errors return 02h with sense prepared.
// RL14 - Busy 08h without disconnect privilege.
// RL15 - Reserved by other initiator returns 18h.
// RL16 - Queue full returns 28h, sense invalid.
// RL17 - Never return 04h, 30h or 40h.
// RL18 - Never return 10h or 14h.
// RL19 - Initiator requests sense after check condition.
// RL20 - Initiator retries later after busy.
// RL21 - Zero count writes to end of unit.
// RL22 - Reference tag increments per following block.
package wscs_pkg;

  localparam int LBA_W = 64;

  localparam logic [7:0] OP_WS16 = 8'h93;
  localparam logic [7:0] OP_VARLEN = 8'h7F;
  localparam logic [7:0] ADL_WS32 = 8'h18;
  localparam logic [15:0] SA_WS32 = 16'h000D;

  localparam int CDB16_LBA = 2;
  localparam int CDB16_LEN = 10;
  localparam int CDB16_GUARD = 1;
  localparam int CDB32_ADL = 7;
  localparam int CDB32_SA = 8;
  localparam int CDB32_GUARD = 10;
  localparam int CDB32_LBA = 12;
  localparam int CDB32_REF = 20;
  localparam int CDB32_APP = 24;
  localparam int CDB32_MASK = 26;
  localparam int CDB32_CNT = 28;
  localparam int GUARD_LSB = 5;
  localparam logic [2:0] PTYPE_TWO = 3'h1;

  localparam logic [7:0] STS_GOOD = 8'h00;
  localparam logic [7:0] STS_CHECK = 8'h02;
  localparam logic [7:0] STS_BUSY = 8'h08;
  localparam logic [7:0] STS_RESV = 8'h18;
  localparam logic [7:0] STS_QFULL = 8'h28;
  localparam logic [7:0] STS_CODE_MASK = 8'h3E;

  localparam logic [3:0] SK_NONE = 4'h0;
  localparam logic [3:0] SK_ILLEGAL = 4'h5;
  localparam logic [3:0] SK_ABORTED = 4'hB;
  localparam logic [7:0] ASC_NONE = 8'h00;
  localparam logic [7:0] ASC_BAD_OPCODE = 8'h20;
  localparam logic [7:0] ASC_LBA_RANGE = 8'h21;
  localparam logic [7:0] ASC_PI_CHECK = 8'h10;

  localparam logic [3:0] REG_CONFIG = 4'h0;
  localparam logic [3:0] REG_CAP_LO = 4'h1;
  localparam logic [3:0] REG_CAP_HI = 4'h2;
  localparam logic [3:0] REG_STATUS = 4'h3;
  localparam logic [3:0] REG_DONE = 4'h4;

  localparam int CFG_PEN_BIT = 0;
  localparam int CFG_PTYPE_LSB = 1;
  localparam int CFG_ATO_BIT = 4;
  localparam int CFG_TQ_BIT = 5;
  localparam int ST_SKEY_LSB = 8;
  localparam int ST_ASC_LSB = 16;

  localparam logic [31:0] CFG_RESET = 32'h0000_0000;

  typedef enum logic [2:0] {
    WSCS_IDLE,
    WSCS_CDB,
    WSCS_DECODE,
    WSCS_DATA,
    WSCS_PICHK,
    WSCS_WRITE
  } wscs_state_t;

endpackage : wscs_pkg

// File: rtl/wscs_write_same.sv
`timescale 1ns/1ps
`default_nettype none
module wscs_write_same
  import wscs_pkg::*;
#(
  parameter int BLK_WORDS = 128
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_byte,
  input wire logic cmd_last,
  output logic cmd_ready,
  input wire logic busy_other,
  input wire logic disc_priv,
  input wire logic reserved_other,
  input wire logic queue_full,
  input wire logic in_valid,
  input wire logic [31:0] in_word,
  output logic in_ready,
  output logic wr_valid,
  input wire logic wr_ready,
  output logic [LBA_W-1:0] wr_lba,
  output logic [31:0] wr_data,
  output logic wr_pi_valid,
  output logic [15:0] wr_guard,
  output logic [15:0] wr_app_tag,
  output logic [31:0] wr_ref_tag,
  output logic status_valid,
  output logic [7:0] status_byte,
  output logic [3:0] sense_key,
  output logic [7:0] sense_asc
);

  localparam int IW = $clog2(BLK_WORDS + 3);
  localparam logic [IW-1:0] BW_L = IW'(BLK_WORDS);
  localparam logic [IW-1:0] ONE_L = IW'(1);

  typedef struct packed {
    wscs_state_t st;
    logic [31:0][7:0] cdb;
    logic [4:0] cidx;
    logic [2:0] write_guard_check_field;
    logic [LBA_W-1:0] lba;
    logic [LBA_W-1:0] left;
    logic [31:0] ref_tag;
    logic [15:0] app_exp;
    logic [15:0] app_mask;
    logic [BLK_WORDS-1:0][31:0] blk;
    logic [IW-1:0] widx;
    logic [15:0] pi_guard;
    logic [15:0] pi_app;
    logic [31:0] pi_ref;
    logic [7:0] status;
    logic stat_vld;
    logic [3:0] skey;
    logic [7:0] asc;
    logic protection_enable_flag;
    logic [2:0] ptype;
    logic app_tag_owner_bit;
    logic tq_enable;
    logic [LBA_W-1:0] cap_last;
    logic [31:0] done_cnt;
    logic [31:0] rdata;
  } wscs_regs_t;

  wscs_regs_t s_ff;
  wscs_regs_t nxt_s;

  function automatic logic [63:0] be_field(input logic [31:0][7:0] c, input int p, input int n);
    logic [63:0] r;
    r = '0;
    for (int i = 0; i < n; i++) begin
      r = {r[55:0], c[5'(p + i)]};
    end
    return r;
  endfunction : be_field

  // Only the five code bits can leave the block, so reserved bits stay zero.
  function automatic logic [7:0] sts_fmt(input logic [7:0] code);
    return code & STS_CODE_MASK; // RL11
  endfunction : sts_fmt

  logic has_pi;
  logic [IW-1:0] last_in;
  logic [31:0] cmd_len;

  assign has_pi = s_ff.protection_enable_flag && (s_ff.write_guard_check_field != 3'h0);
  assign last_in = has_pi ? BW_L + ONE_L : BW_L - ONE_L;

  always_comb begin
    nxt_s = s_ff;
    nxt_s.stat_vld = 1'b0;
    nxt_s.rdata = '0;
    cmd_len = '0;

    if (reg_wr) begin
      case (reg_addr)
        REG_CONFIG: begin
          nxt_s.protection_enable_flag = reg_wdata[CFG_PEN_BIT];
          nxt_s.ptype = reg_wdata[CFG_PTYPE_LSB +: 3];
          nxt_s.app_tag_owner_bit = reg_wdata[CFG_ATO_BIT];
          nxt_s.tq_enable = reg_wdata[CFG_TQ_BIT];
        end
        REG_CAP_LO: nxt_s.cap_last[31:0] = reg_wdata;
        REG_CAP_HI: nxt_s.cap_last[63:32] = reg_wdata;
        default: ;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        REG_CONFIG: begin
          nxt_s.rdata[CFG_PEN_BIT] = s_ff.protection_enable_flag;
          nxt_s.rdata[CFG_PTYPE_LSB +: 3] = s_ff.ptype;
          nxt_s.rdata[CFG_ATO_BIT] = s_ff.app_tag_owner_bit;
          nxt_s.rdata[CFG_TQ_BIT] = s_ff.tq_enable;
        end
        REG_CAP_LO: nxt_s.rdata = s_ff.cap_last[31:0];
        REG_CAP_HI: nxt_s.rdata = s_ff.cap_last[63:32];
        REG_STATUS: begin
          nxt_s.rdata[7:0] = s_ff.status;
          nxt_s.rdata[ST_SKEY_LSB +: 4] = s_ff.skey;
          nxt_s.rdata[ST_ASC_LSB +: 8] = s_ff.asc;
        end
        REG_DONE: nxt_s.rdata = s_ff.done_cnt;
        default: nxt_s.rdata = '0;
      endcase
    end

    case (s_ff.st)
      WSCS_IDLE: begin
        if (cmd_valid) begin
          nxt_s.cdb = '0;
          nxt_s.cdb[0] = cmd_byte;
          nxt_s.cidx = 5'h01;
          nxt_s.st = cmd_last ? WSCS_DECODE : WSCS_CDB;
        end
      end
      WSCS_CDB: begin
        if (cmd_valid) begin
          nxt_s.cdb[s_ff.cidx] = cmd_byte;
          if (s_ff.cidx != 5'h1F) begin
            nxt_s.cidx = s_ff.cidx + 5'h01;
          end
          if (cmd_last) begin
            nxt_s.st = WSCS_DECODE;
          end
        end
      end
      WSCS_DECODE: begin
        nxt_s.stat_vld = 1'b1; // RL10
        nxt_s.st = WSCS_IDLE;
        nxt_s.skey = SK_NONE;
        nxt_s.asc = ASC_NONE;
        nxt_s.widx = '0;
        nxt_s.pi_guard = '0;
        nxt_s.pi_app = '0;
        nxt_s.pi_ref = '0;
        if (busy_other && !disc_priv) begin
          nxt_s.status = sts_fmt(STS_BUSY); // RL14
        end else if (s_ff.tq_enable && queue_full) begin
          nxt_s.status = sts_fmt(STS_QFULL); // RL16
        end else if (reserved_other) begin
          nxt_s.status = sts_fmt(STS_RESV); // RL15
        end else if (s_ff.cdb[0] == OP_WS16) begin
          nxt_s.lba = be_field(s_ff.cdb, CDB16_LBA, 8); // RL1
          cmd_len = 32'(be_field(s_ff.cdb, CDB16_LEN, 4)); // RL1
          nxt_s.write_guard_check_field = s_ff.cdb[CDB16_GUARD][GUARD_LSB +: 3];
          nxt_s.ref_tag = nxt_s.lba[31:0];
          nxt_s.app_exp = '0;
          nxt_s.app_mask = '0;
          nxt_s.stat_vld = 1'b0;
          nxt_s.st = WSCS_DATA;
        end else if (s_ff.cdb[0] == OP_VARLEN && s_ff.cdb[CDB32_ADL] == ADL_WS32 &&
                     16'(be_field(s_ff.cdb, CDB32_SA, 2)) == SA_WS32) begin // RL3
          if (s_ff.protection_enable_flag && s_ff.ptype == PTYPE_TWO) begin // RL5
            nxt_s.lba = be_field(s_ff.cdb, CDB32_LBA, 8); // RL4
            cmd_len = 32'(be_field(s_ff.cdb, CDB32_CNT, 4)); // RL4
            nxt_s.write_guard_check_field = s_ff.cdb[CDB32_GUARD][GUARD_LSB +: 3];
            nxt_s.ref_tag = 32'(be_field(s_ff.cdb, CDB32_REF, 4)); // RL6
            nxt_s.app_exp = 16'(be_field(s_ff.cdb, CDB32_APP, 2));
            nxt_s.app_mask = 16'(be_field(s_ff.cdb, CDB32_MASK, 2));
            nxt_s.stat_vld = 1'b0;
            nxt_s.st = WSCS_DATA;
          end else begin
            nxt_s.status = sts_fmt(STS_CHECK); // RL5
            nxt_s.skey = SK_ILLEGAL;
            nxt_s.asc = ASC_BAD_OPCODE;
          end
        end else begin
          nxt_s.status = sts_fmt(STS_CHECK); // RL13
          nxt_s.skey = SK_ILLEGAL;
          nxt_s.asc = ASC_BAD_OPCODE;
        end
        if (nxt_s.st == WSCS_DATA) begin
          if (nxt_s.lba > s_ff.cap_last) begin
            nxt_s.status = sts_fmt(STS_CHECK); // RL13
            nxt_s.skey = SK_ILLEGAL;
            nxt_s.asc = ASC_LBA_RANGE;
            nxt_s.stat_vld = 1'b1;
            nxt_s.st = WSCS_IDLE;
          end else if (cmd_len == 32'h0000_0000) begin
            nxt_s.left = s_ff.cap_last - nxt_s.lba + 64'h0000_0000_0000_0001; // RL21
          end else begin
            nxt_s.left = {32'h0000_0000, cmd_len};
          end
        end
      end
      WSCS_DATA: begin
        if (in_valid) begin
          if (s_ff.widx < BW_L) begin
            nxt_s.blk[s_ff.widx] = in_word; // RL2
          end else if (s_ff.widx == BW_L) begin
            nxt_s.pi_guard = in_word[31:16];
            nxt_s.pi_app = in_word[15:0];
          end else begin
            nxt_s.pi_ref = in_word;
          end
          if (s_ff.widx == last_in) begin
            nxt_s.widx = '0;
            nxt_s.st = has_pi ? WSCS_PICHK : WSCS_WRITE;
          end else begin
            nxt_s.widx = s_ff.widx + ONE_L;
          end
        end
      end
      WSCS_PICHK: begin
        // Tag mismatches abort before any block reaches the medium.
        if (s_ff.pi_ref != s_ff.ref_tag || // RL6
            (s_ff.app_tag_owner_bit && ((s_ff.pi_app ^ s_ff.app_exp) & s_ff.app_mask) != 16'h0000)) begin // RL7 RL8
          nxt_s.status = sts_fmt(STS_CHECK); // RL13
          nxt_s.skey = SK_ABORTED;
          nxt_s.asc = ASC_PI_CHECK;
          nxt_s.stat_vld = 1'b1;
          nxt_s.st = WSCS_IDLE;
        end else begin
          nxt_s.st = WSCS_WRITE;
        end
      end
      WSCS_WRITE: begin
        if (wr_ready) begin
          if (s_ff.widx == BW_L - ONE_L) begin
            nxt_s.widx = '0;
            nxt_s.lba = s_ff.lba + 64'h0000_0000_0000_0001; // RL2
            nxt_s.ref_tag = s_ff.ref_tag + 32'h0000_0001; // RL22
            nxt_s.left = s_ff.left - 64'h0000_0000_0000_0001;
            nxt_s.done_cnt = s_ff.done_cnt + 32'h0000_0001;
            if (s_ff.left == 64'h0000_0000_0000_0001) begin
              nxt_s.status = sts_fmt(STS_GOOD); // RL12
              nxt_s.stat_vld = 1'b1; // RL10
              nxt_s.st = WSCS_IDLE;
            end
          end else begin
            nxt_s.widx = s_ff.widx + ONE_L;
          end
        end
      end
      default: nxt_s.st = WSCS_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign reg_rdata = s_ff.rdata;
  assign cmd_ready = (s_ff.st == WSCS_IDLE) || (s_ff.st == WSCS_CDB);
  assign in_ready = (s_ff.st == WSCS_DATA);
  assign wr_valid = (s_ff.st == WSCS_WRITE);
  assign wr_lba = s_ff.lba;
  assign wr_data = s_ff.blk[s_ff.widx];
  assign wr_pi_valid = s_ff.protection_enable_flag; // RL9
  assign wr_guard = s_ff.pi_guard;
  assign wr_app_tag = s_ff.pi_app;
  assign wr_ref_tag = s_ff.ref_tag;
  // Only the five documented codes are ever loaded into the status field.
  assign status_valid = s_ff.stat_vld; // RL17 RL18
  assign status_byte = s_ff.status;
  assign sense_key = s_ff.skey;
  assign sense_asc = s_ff.asc;

endmodule : wscs_write_same
`default_nettype wire

// File: testbench/wscs_props.sv
`timescale 1ns/1ps
`default_nettype none
module wscs_props
  import wscs_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic cmd_valid,
  input wire logic cmd_last,
  input wire logic cmd_ready,
  input wire logic busy_other,
  input wire logic disc_priv,
  input wire logic reserved_other,
  input wire logic queue_full,
  input wire logic status_valid,
  input wire logic [7:0] status_byte,
  input wire logic [3:0] sense_key,
  input wire logic [7:0] sense_asc
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  a_sts_rsvd_zero: assert property (status_valid |-> (status_byte & ~STS_CODE_MASK) == 8'h00)
    else $error("status reserved bits set");
  a_no_unsupported: assert property (status_valid |-> !(status_byte inside {8'h04, 8'h30, 8'h40}))
    else $error("unsupported status code");
  a_no_obsolete: assert property (status_valid |-> !(status_byte inside {8'h10, 8'h14}))
    else $error("obsolete status code");
  a_busy_refusal: assert property (cmd_valid && cmd_ready && cmd_last ##1 busy_other && !disc_priv
    |=> status_valid && status_byte == STS_BUSY) else $error("busy status missing");
  a_resv_refusal: assert property (cmd_valid && cmd_ready && cmd_last ##1 reserved_other &&
    !(busy_other && !disc_priv) && !queue_full |=> status_valid && status_byte == STS_RESV)
    else $error("reservation status missing");
  a_check_sense: assert property (status_valid && status_byte == STS_CHECK |-> sense_key != 4'h0)
    else $error("check condition without sense");
  a_qfull_nosense: assert property (status_valid && status_byte == STS_QFULL |->
    sense_key == 4'h0 && sense_asc == 8'h00) else $error("queue full carries sense");
  a_single_status: assert property (status_valid |=> !status_valid)
    else $error("status pulse too long");
endmodule : wscs_props
bind wscs_write_same wscs_props u_props (
  .mclk(mclk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_last(cmd_last), .cmd_ready(cmd_ready),
  .busy_other(busy_other), .disc_priv(disc_priv), .reserved_other(reserved_other), .queue_full(queue_full),
  .status_valid(status_valid), .status_byte(status_byte), .sense_key(sense_key), .sense_asc(sense_asc)
);
`default_nettype wire

// File: testbench/wscs_host.sv
`timescale 1ns/1ps
`default_nettype none
module wscs_host (
  input wire logic mclk,
  input wire logic cmd_ready,
  input wire logic in_ready,
  output logic cmd_valid,
  output logic [7:0] cmd_byte,
  output logic cmd_last,
  output logic in_valid,
  output logic [31:0] in_word
);
  logic [7:0] cdb [32];
  logic [31:0] dat [6];
  int gap = 0;
  initial begin
    cmd_valid = 1'b0;
    cmd_last = 1'b0;
    cmd_byte = 8'h00;
    in_valid = 1'b0;
    in_word = 32'h0000_0000;
  end
  task automatic send_cmd(input int n);
    for (int i = 0; i < n; i++) begin
      cmd_valid <= 1'b1;
      cmd_byte <= cdb[i];
      cmd_last <= (i == n - 1);
      @(negedge mclk);
      while (!cmd_ready) @(negedge mclk);
      @(posedge mclk);
    end
    cmd_valid <= 1'b0;
    cmd_last <= 1'b0;
    cmd_byte <= ~cdb[n - 1];
  endtask : send_cmd
  // Between words the data lines carry a changing pattern, never the last word.
  task automatic send_data(input int n);
    for (int i = 0; i < n; i++) begin
      if (gap > 0) begin
        in_valid <= 1'b0;
        in_word <= ~dat[i];
        repeat (gap) @(posedge mclk);
      end
      in_valid <= 1'b1;
      in_word <= dat[i];
      @(negedge mclk);
      while (!in_ready) @(negedge mclk);
      @(posedge mclk);
    end
    in_valid <= 1'b0;
    in_word <= ~dat[n - 1];
  endtask : send_data
endmodule : wscs_host
`default_nettype wire

// File: testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import wscs_pkg::*;
;
  localparam int BW = 4;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic busy_other = 1'b0;
  logic disc_priv = 1'b0;
  logic reserved_other = 1'b0;
  logic queue_full = 1'b0;
  logic wr_ready = 1'b0;
  logic cmd_valid, cmd_last, cmd_ready, in_valid, in_ready, wr_valid, wr_pi_valid, status_valid;
  logic [7:0] cmd_byte, status_byte, sense_asc;
  logic [31:0] reg_rdata, in_word, wr_data, wr_ref_tag;
  logic [LBA_W-1:0] wr_lba;
  logic [15:0] wr_guard, wr_app_tag;
  logic [3:0] sense_key;
  int bad_count = 0;
  int check_count = 0;
  int beats = 0;
  logic pen = 1'b0;
  logic [63:0] base = 64'h0;
  logic [31:0] rtag = 32'h0;
  wscs_write_same #(.BLK_WORDS(BW)) uut (
    .mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte), .cmd_last(cmd_last),
    .cmd_ready(cmd_ready), .busy_other(busy_other), .disc_priv(disc_priv), .reserved_other(reserved_other),
    .queue_full(queue_full), .in_valid(in_valid), .in_word(in_word), .in_ready(in_ready),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_lba(wr_lba), .wr_data(wr_data), .wr_pi_valid(wr_pi_valid),
    .wr_guard(wr_guard), .wr_app_tag(wr_app_tag), .wr_ref_tag(wr_ref_tag), .status_valid(status_valid),
    .status_byte(status_byte), .sense_key(sense_key), .sense_asc(sense_asc)
  );
  wscs_host host (
    .mclk(mclk), .cmd_ready(cmd_ready), .in_ready(in_ready), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
    .cmd_last(cmd_last), .in_valid(in_valid), .in_word(in_word)
  );
  initial begin
    forever #2.5 mclk = ~mclk;
  end
  task automatic chk(string nm, logic [63:0] e, logic [63:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : final_report
  // The medium stalls at random, so beats that follow a stall also test holding.
  always @(posedge mclk) begin
    wr_ready <= ($urandom_range(0, 3) != 0);
    if (wr_valid && wr_ready) begin
      chk("wr_data", host.dat[beats % BW], wr_data);
      chk("wr_lba", base + beats / BW, wr_lba);
      chk("wr_pi_valid", pen, wr_pi_valid);
      if (pen) chk("wr_ref_tag", rtag + beats / BW, wr_ref_tag);
      chk("wr_guard", pen ? {48'h0, host.dat[4][31:16]} : 64'h0, wr_guard);
      chk("wr_app_tag", pen ? {48'h0, host.dat[4][15:0]} : 64'h0, wr_app_tag);
      beats++;
    end
  end
  task automatic wr(logic [3:0] a, logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(posedge mclk);
  endtask : wr
  task automatic rd(logic [3:0] a, logic [31:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    chk("reg_rdata", e, reg_rdata);
    @(posedge mclk);
  endtask : rd
  task automatic put(int at, int n, logic [63:0] v);
    for (int i = 0; i < n; i++) host.cdb[at + i] = v[8 * (n - 1 - i) +: 8];
  endtask : put
  task automatic cdb16(logic [63:0] lba, logic [31:0] cnt);
    foreach (host.cdb[i]) host.cdb[i] = 8'h00;
    host.cdb[0] = OP_WS16;
    put(2, 8, lba);
    put(10, 4, {32'h0, cnt});
  endtask : cdb16
  task automatic run(int nc, int nw, logic [7:0] s, logic [3:0] k, logic [7:0] a, int nb);
    int i;
    i = 0;
    beats = 0;
    host.gap = $urandom_range(0, 1);
    host.send_cmd(nc);
    if (nw > 0) host.send_data(nw);
    do @(negedge mclk); while (status_valid !== 1'b1 && ++i < 3000);
    chk("status_valid", 64'h1, status_valid);
    chk("status_byte", s, status_byte);
    if (s != STS_GOOD) chk("sense_key", k, sense_key);
    if (s != STS_GOOD) chk("sense_asc", a, sense_asc);
    chk("beats", nb * BW, beats);
    @(posedge mclk);
  endtask : run
  initial begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    final_report();
  end
  initial begin
    static logic [31:0] pc [4] = '{32'h13, 32'h13, 32'h03, 32'h03};
    static logic [15:0] px [4] = '{16'h00FF, 16'h0100, 16'hFFFF, 16'h0000};
    static logic [7:0] ps [4] = '{STS_GOOD, STS_CHECK, STS_GOOD, STS_CHECK};
    void'($urandom(32'h2c42));
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    rd(REG_CONFIG, CFG_RESET);
    rd(4'hF, 32'h0000_0000);
    wr(REG_STATUS, 32'hFFFF_FFFF);
    rd(REG_STATUS, 32'h0000_0000);
    wr(REG_CAP_LO, 32'h0000_000F);
    wr(REG_CAP_HI, 32'h0000_0000);
    foreach (host.dat[i]) host.dat[i] = $urandom;
    base = $urandom_range(0, 10);
    cdb16(base, 32'h2);
    busy_other <= 1'b1;
    run(16, 0, STS_BUSY, 4'h0, 8'h00, 0);
    disc_priv <= 1'b1;
    run(16, BW, STS_GOOD, 4'h0, 8'h00, 2);
    rd(REG_DONE, 32'h0000_0002);
    reserved_other <= 1'b1;
    run(16, 0, STS_RESV, 4'h0, 8'h00, 0);
    reserved_other <= 1'b0;
    wr(REG_CONFIG, 32'h0000_0020);
    queue_full <= 1'b1;
    run(16, 0, STS_QFULL, SK_NONE, ASC_NONE, 0);
    queue_full <= 1'b0;
    host.cdb[0] = 8'h41;
    run(16, 0, STS_CHECK, SK_ILLEGAL, ASC_BAD_OPCODE, 0);
    rd(REG_STATUS, {8'h00, ASC_BAD_OPCODE, 4'h0, SK_ILLEGAL, STS_CHECK});
    cdb16(64'h0000_0000_0000_0010, 32'h1);
    run(16, 0, STS_CHECK, SK_ILLEGAL, ASC_LBA_RANGE, 0);
    base = 64'h0000_0000_0000_000E;
    cdb16(base, 32'h0);
    run(16, BW, STS_GOOD, 4'h0, 8'h00, 2);
    foreach (pc[i]) begin
      wr(REG_CONFIG, i < 2 ? 32'h0000_0000 + 32'(i * 5) : pc[i]);
      pen = (i >= 2);
      base = $urandom_range(0, 10);
      rtag = $urandom;
      foreach (host.cdb[j]) host.cdb[j] = 8'h00;
      host.cdb[0] = OP_VARLEN;
      host.cdb[7] = ADL_WS32;
      put(8, 2, {48'h0, SA_WS32});
      host.cdb[10] = 8'h20;
      put(12, 8, base);
      put(20, 4, {32'h0, rtag});
      put(24, 4, 64'h0000_0000_A5C3_FF00);
      put(28, 4, 64'h2);
      if (i < 2) run(32, 0, STS_CHECK, SK_ILLEGAL, ASC_BAD_OPCODE, 0);
    end
    foreach (pc[i]) begin
      wr(REG_CONFIG, pc[i]);
      host.dat[4] = {16'h1234, 16'hA5C3 ^ px[i]};
      host.dat[5] = rtag + 32'(i / 3);
      run(32, BW + 2, ps[i], SK_ABORTED, ASC_PI_CHECK, ps[i] == STS_GOOD ? 2 : 0);
    end
    // The short form with protection expects the low address bits as the first reference tag.
    base = $urandom_range(0, 10);
    rtag = base[31:0];
    cdb16(base, 32'h0000_0001);
    host.cdb[1] = 8'h20;
    host.dat[5] = rtag;
    run(16, BW + 2, STS_GOOD, 4'h0, 8'h00, 1);
    final_report();
  end
endmodule : tb_top
`default_nettype wire
